// ---- design/eco_pkg.sv ----
package eco_pkg;
  // ==========================================================
  // Sizes
  localparam int          NUM_CH      = 8;
  localparam int          ADDR_W      = 8;
  localparam int          IDX_W       = 16;
  localparam int          SUB_W       = 8;
  localparam int          SLOT_W      = 8;

  // ==========================================================
  // Process image map
  localparam logic [7:0]  OUT_OFFSET  = 8'h00;
  localparam logic [7:0]  OUT_RESET   = 8'h00;

  // ==========================================================
  // Field-bus object addressing
  localparam logic [15:0] CO_INDEX    = 16'h6200;
  localparam logic [15:0] EC_BASE     = 16'h7000;
  localparam logic [7:0]  SUB_FIRST   = 8'h01;
  localparam logic [7:0]  SUB_LAST    = 8'h08;

  // ==========================================================
  // Status inputs, bit positions in the synchronised vector
  localparam int          ST_W        = 4;
  localparam int          ST_BUS_OK   = 0;
  localparam int          ST_FAULT    = 1;
  localparam int          ST_PWR_FAIL = 2;
  localparam int          ST_CFG_ERR  = 3;
  localparam logic [3:0]  ST_RESET    = 4'h0;

  // ==========================================================
  // Timing
  localparam longint      CLK_HZ      = 100_000_000;
  localparam longint      BLINK_HZ    = 2;
  localparam int          BLINK_HALF  = int'(CLK_HZ / (2 * BLINK_HZ));
endpackage : eco_pkg

// ---- design/eco_top.sv ----
`timescale 1ns/1ps
module eco_top
  import eco_pkg::*;
#(
  parameter int BLINK_HALF_CYC = eco_pkg::BLINK_HALF
) (
  // Clock and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_srst,
  // Process image write
  input  wire logic                        i_pa_wr,
  input  wire logic [eco_pkg::ADDR_W-1:0]  i_pa_addr,
  input  wire logic [eco_pkg::NUM_CH-1:0]  i_pa_data,
  // CANopen object write
  input  wire logic                        i_co_wr,
  input  wire logic [eco_pkg::IDX_W-1:0]   i_canopen_object_index,
  input  wire logic [eco_pkg::SUB_W-1:0]   i_co_subindex,
  input  wire logic                        i_co_bit,
  // EtherCAT object write
  input  wire logic                        i_ec_wr,
  input  wire logic [eco_pkg::SLOT_W-1:0]  i_ec_slot,
  input  wire logic [eco_pkg::IDX_W-1:0]   i_ec_index,
  input  wire logic [eco_pkg::SUB_W-1:0]   i_ethercat_object_subindex,
  input  wire logic                        i_ec_bit,
  // Module status pins
  input  wire logic                        i_bus_ok,
  input  wire logic                        i_out_fault,
  input  wire logic                        i_bus_pwr_fail,
  input  wire logic                        i_cfg_err,
  // Channel outputs and lamps
  output logic      [eco_pkg::NUM_CH-1:0]  o_output_image_byte,
  output logic      [eco_pkg::NUM_CH-1:0]  o_chan_lamp,
  output logic                             o_run_lamp,
  output logic                             o_module_fault_lamp
);
  import eco_pkg::*;

  localparam int CNT_W = $clog2(BLINK_HALF_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BLINK_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // ==========================================================
  // Status pin synchronisers
  logic [ST_W-1:0] s1_r, s2_r, s3_r, st_r;
  logic [ST_W-1:0] s1_nxt, s2_nxt, s3_nxt, st_nxt;

  always_comb begin
    s1_nxt = {i_cfg_err, i_bus_pwr_fail, i_out_fault, i_bus_ok};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    st_nxt = st_r;
    // A bit counts only once the second and third stage agree
    for (int i = 0; i < ST_W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        st_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s1_r <= ST_RESET;
      s2_r <= ST_RESET;
      s3_r <= ST_RESET;
      st_r <= ST_RESET;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      st_r <= st_nxt;
    end
  end

  wire logic bus_ok   = st_r[ST_BUS_OK];
  wire logic fault    = st_r[ST_FAULT];
  wire logic pwr_fail = st_r[ST_PWR_FAIL];
  wire logic cfg_err  = st_r[ST_CFG_ERR];

  // ==========================================================
  // Output image
  logic [NUM_CH-1:0] out_r, out_nxt;

  function automatic logic sub_ok(input logic [SUB_W-1:0] sub);
    sub_ok = (sub >= SUB_FIRST) && (sub <= SUB_LAST);
  endfunction : sub_ok

  wire logic [IDX_W-1:0] ec_index = IDX_W'(EC_BASE + {8'h00, i_ec_slot});
  wire logic pa_hit = i_pa_wr && (i_pa_addr == OUT_OFFSET);
  wire logic co_hit = i_co_wr && (i_canopen_object_index == CO_INDEX)
                      && sub_ok(i_co_subindex);
  wire logic ec_hit = i_ec_wr && (i_ec_index == ec_index)
                      && sub_ok(i_ethercat_object_subindex);
  wire logic [2:0] co_ch = 3'(i_co_subindex - SUB_FIRST);
  wire logic [2:0] ec_ch = 3'(i_ethercat_object_subindex - SUB_FIRST);

  // Whole-byte write wins over single-bit object writes in one cycle
  always_comb begin
    out_nxt = out_r;
    if (pa_hit) begin
      out_nxt = i_pa_data;
    end else begin
      if (co_hit) begin
        out_nxt[co_ch] = i_co_bit;
      end
      if (ec_hit) begin
        out_nxt[ec_ch] = i_ec_bit;
      end
    end
  end

  // No read path exists at all, so nothing leaks back to the head
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      out_r <= OUT_RESET;
    end else begin
      out_r <= out_nxt;
    end
  end

  // ==========================================================
  // Blink timer, restarted so each error begins with a full lit phase
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             blink_r, blink_nxt;

  always_comb begin
    cnt_nxt   = CNT_ZERO;
    blink_nxt = 1'b1;
    if (cfg_err) begin
      cnt_nxt   = (cnt_r == CNT_LAST) ? CNT_ZERO : cnt_r + 1'b1;
      blink_nxt = (cnt_r == CNT_LAST) ? ~blink_r : blink_r;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt_r   <= CNT_ZERO;
      blink_r <= 1'b1;
    end else begin
      cnt_r   <= cnt_nxt;
      blink_r <= blink_nxt;
    end
  end

  // ==========================================================
  // Lamps and pins, all registered
  logic run_nxt, flt_lamp_nxt;

  // Power failure outranks everything, so a dead supply never shows a fault
  always_comb begin
    run_nxt = bus_ok && !pwr_fail;
    if (pwr_fail) begin
      flt_lamp_nxt = 1'b0;
    end else if (cfg_err) begin
      flt_lamp_nxt = blink_r;
    end else begin
      flt_lamp_nxt = fault;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_output_image_byte <= OUT_RESET;
      o_chan_lamp         <= OUT_RESET;
      o_run_lamp          <= 1'b0;
      o_module_fault_lamp <= 1'b0;
    end else begin
      o_output_image_byte <= out_nxt;
      o_chan_lamp         <= out_nxt;
      o_run_lamp          <= run_nxt;
      o_module_fault_lamp <= flt_lamp_nxt;
    end
  end

  // ==========================================================
  // Assertions
  // Timer wraps, then the error is still there when the lamp is loaded
  sequence s_blink_wrap;
    cfg_err && !pwr_fail && cnt_r == CNT_LAST ##1 cfg_err && !pwr_fail;
  endsequence

  a_byte_write: assert property (@(posedge i_mclk) disable iff (i_srst)
    pa_hit |=> o_output_image_byte == $past(i_pa_data))
    else $error("Byte write not on outputs");

  a_co_bit: assert property (@(posedge i_mclk) disable iff (i_srst)
    co_hit && !pa_hit && !ec_hit
    |=> o_output_image_byte[$past(co_ch)] == $past(i_co_bit))
    else $error("CANopen bit write lost");

  a_ec_bit: assert property (@(posedge i_mclk) disable iff (i_srst)
    ec_hit && !pa_hit
    |=> o_output_image_byte[$past(ec_ch)] == $past(i_ec_bit))
    else $error("EtherCAT bit write lost");

  a_lamp_follow: assert property (@(posedge i_mclk)
    disable iff (i_srst) o_chan_lamp == o_output_image_byte)
    else $error("Channel lamp differs from output");

  a_run_ok: assert property (@(posedge i_mclk) disable iff (i_srst)
    bus_ok && !pwr_fail && !fault && !cfg_err
    |=> o_run_lamp && !o_module_fault_lamp)
    else $error("Healthy module lamps wrong");

  a_fault_on: assert property (@(posedge i_mclk) disable iff (i_srst)
    fault && !cfg_err && !pwr_fail |=> o_module_fault_lamp)
    else $error("Fault lamp not lit");

  a_run_off: assert property (@(posedge i_mclk) disable iff (i_srst)
    !bus_ok |=> !o_run_lamp)
    else $error("Run lamp on without bus");

  a_pwr_dark: assert property (@(posedge i_mclk) disable iff (i_srst)
    pwr_fail |=> !o_run_lamp && !o_module_fault_lamp)
    else $error("Lamps lit on power failure");

  a_blink_phase: assert property (@(posedge i_mclk)
    disable iff (i_srst)
    s_blink_wrap |=> o_module_fault_lamp != $past(o_module_fault_lamp))
    else $error("Fault lamp did not toggle");

  a_reset_zero: assert property (@(posedge i_mclk)
    $past(i_srst) && !i_srst
    |-> o_output_image_byte == OUT_RESET && o_chan_lamp == OUT_RESET)
    else $error("Outputs not zero after reset");
endmodule : eco_top

// ---- verif/eco_head.sv ----
`timescale 1ns/1ps
// ==========================================================
// Head station model: one-cycle write strobes, data inverted
// once released so stale values never look valid
module eco_head
  import eco_pkg::*;
(
  input  wire logic        i_mclk,
  output logic             o_pa_wr,
  output logic [7:0]       o_pa_addr,
  output logic [7:0]       o_pa_data,
  output logic             o_co_wr,
  output logic [15:0]      o_co_idx,
  output logic [7:0]       o_co_sub,
  output logic             o_co_bit,
  output logic             o_ec_wr,
  output logic [7:0]       o_ec_slot,
  output logic [15:0]      o_ec_idx,
  output logic [7:0]       o_ec_sub,
  output logic             o_ec_bit
);
  initial begin
    {o_pa_wr, o_pa_addr, o_pa_data} = '0;
    {o_co_wr, o_co_idx, o_co_sub, o_co_bit} = '0;
    {o_ec_wr, o_ec_slot, o_ec_idx, o_ec_sub, o_ec_bit} = '0;
  end
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk) #1;
    {o_pa_wr, o_pa_addr, o_pa_data} = {1'b1, a, d};
    @(posedge i_mclk) #1;
    {o_pa_wr, o_pa_data} = {1'b0, ~d};
  endtask : wr_byte
  task automatic wr_co(input logic [15:0] x, input logic [7:0] s,
                       input logic b);
    @(posedge i_mclk) #1;
    {o_co_wr, o_co_idx, o_co_sub, o_co_bit} = {1'b1, x, s, b};
    @(posedge i_mclk) #1;
    {o_co_wr, o_co_bit} = {1'b0, ~b};
  endtask : wr_co
  task automatic wr_ec(input logic [7:0] sl, input logic [15:0] x,
                       input logic [7:0] s, input logic b);
    @(posedge i_mclk) #1;
    {o_ec_wr, o_ec_slot, o_ec_idx, o_ec_sub, o_ec_bit} =
      {1'b1, sl, x, s, b};
    @(posedge i_mclk) #1;
    {o_ec_wr, o_ec_bit} = {1'b0, ~b};
  endtask : wr_ec
endmodule : eco_head

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
  end end
module tb_top;
  import eco_pkg::*;
  // Short blink period keeps the run brief
  localparam int HALF = 8;
  logic clk = 0, srst = 1, bus_ok = 0, flt = 0, pwr = 0, cfg = 0;
  logic pa_wr, co_wr, co_bit, ec_wr, ec_bit, run, flamp;
  logic [7:0] pa_addr, pa_data, co_sub, ec_slot, ec_sub, outb, lamp;
  logic [15:0] co_idx, ec_idx;
  int mismatches = 0, checks_done = 0, n;
  always #5 clk = ~clk;
  eco_head u_head (.i_mclk(clk), .o_pa_wr(pa_wr), .o_pa_addr(pa_addr),
    .o_pa_data(pa_data), .o_co_wr(co_wr), .o_co_idx(co_idx),
    .o_co_sub(co_sub), .o_co_bit(co_bit), .o_ec_wr(ec_wr),
    .o_ec_slot(ec_slot), .o_ec_idx(ec_idx), .o_ec_sub(ec_sub),
    .o_ec_bit(ec_bit));
  eco_top #(.BLINK_HALF_CYC(HALF)) u_dut (.i_mclk(clk), .i_srst(srst),
    .i_pa_wr(pa_wr), .i_pa_addr(pa_addr), .i_pa_data(pa_data),
    .i_co_wr(co_wr), .i_canopen_object_index(co_idx),
    .i_co_subindex(co_sub), .i_co_bit(co_bit), .i_ec_wr(ec_wr),
    .i_ec_slot(ec_slot), .i_ec_index(ec_idx),
    .i_ethercat_object_subindex(ec_sub), .i_ec_bit(ec_bit),
    .i_bus_ok(bus_ok), .i_out_fault(flt), .i_bus_pwr_fail(pwr),
    .i_cfg_err(cfg), .o_output_image_byte(outb), .o_chan_lamp(lamp),
    .o_run_lamp(run), .o_module_fault_lamp(flamp));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ==========================================================
  // Helper tasks
  task automatic chk_out(input logic [7:0] e);
    `CHK(outb, e)
    `CHK(lamp, e)
  endtask : chk_out
  // Pins pass a synchroniser, so allow it to settle first
  task automatic pins(input logic [3:0] p, input logic r, input logic f);
    {cfg, pwr, flt, bus_ok} = p;
    repeat (8) @(posedge clk);
    #1;
    `CHK(run, r)
    `CHK(flamp, f)
  endtask : pins
  // Cycles from one fault lamp change to the next
  task automatic gap();
    logic v;
    n = 0;
    v = flamp;
    do begin
      @(posedge clk) #1;
      n++;
    end while (flamp === v && n < 20);
    // Limit spent without a change: count it and stop
    if (flamp === v) begin
      mismatches++;
      conclude();
    end
  endtask : gap
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    #1 srst = 0;
    chk_out(8'h00);
    `CHK(flamp, 1'b0)
    u_head.wr_byte(8'h01, 8'hff);
    chk_out(8'h00);
    u_head.wr_byte(OUT_OFFSET, 8'ha5);
    chk_out(8'ha5);
    $display("test byte done");
    for (int i = 0; i < 8; i++) begin
      u_head.wr_co(CO_INDEX, 8'(i + 1), i[0]);
    end
    chk_out(8'haa);
    u_head.wr_co(16'h6201, SUB_FIRST, 1'b1);
    u_head.wr_co(CO_INDEX, 8'h09, 1'b1);
    u_head.wr_co(CO_INDEX, 8'h00, 1'b1);
    chk_out(8'haa);
    $display("test canopen done");
    for (int i = 0; i < 8; i++) begin
      u_head.wr_ec(8'hff, 16'h70ff, 8'(i + 1), 1'b1);
    end
    chk_out(8'hff);
    u_head.wr_ec(8'hff, EC_BASE, SUB_LAST, 1'b0);
    chk_out(8'hff);
    $display("test ethercat done");
    pins(4'b0001, 1'b1, 1'b0);
    pins(4'b0011, 1'b1, 1'b1);
    pins(4'b0010, 1'b0, 1'b1);
    pins(4'b0111, 1'b0, 1'b0);
    pins(4'b1001, 1'b1, 1'b1);
    gap();
    gap();
    `CHK(n, HALF)
    gap();
    `CHK(n, HALF)
    chk_out(8'hff);
    $display("test lamps done");
    // Reset in mid-run must clear a lit output byte again
    @(posedge clk) #1 srst = 1;
    repeat (2) @(posedge clk);
    #1 srst = 0;
    chk_out(8'h00);
    u_head.wr_byte(OUT_OFFSET, 8'h3c);
    chk_out(8'h3c);
    $display("test reset done");
    conclude();
  end
endmodule : tb_top
